// *** design/enbi_pkg.sv ***
// Package with register map, field layout and types of the national bit insertion block
package enbi_pkg;

  // ****************************************************************
  // Register indices (byte address is four times the index)
  // ****************************************************************
  localparam logic [9:0] IDX_LINK_SELECT = 10'h10a;
  localparam logic [9:0] IDX_REG_SOURCE = 10'h130;
  localparam logic [9:0] IDX_AUTO_REPLY = 10'h131;
  localparam logic [9:0] IDX_STATUS = 10'h132;
  localparam logic [9:0] IDX_PATTERN4 = 10'h133;
  localparam logic [9:0] IDX_PATTERN5 = 10'h134;
  localparam logic [9:0] IDX_PATTERN6 = 10'h135;
  localparam logic [9:0] IDX_PATTERN7 = 10'h136;
  localparam logic [9:0] IDX_PATTERN8 = 10'h137;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] PATTERN_RST = 8'hff;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ****************************************************************
  // Field positions: control words carry Sa4..Sa8 in bits 4..0
  // ****************************************************************
  localparam int SA4_POS = 4;
  localparam int SA5_POS = 3;
  localparam int SA6_POS = 2;
  localparam int SA7_POS = 1;
  localparam int SA8_POS = 0;
  localparam int AIS_ONE_POS = 7;
  localparam int AIS_TWO_POS = 6;
  localparam int FAR_END_BLOCK_ERROR_SEL_HI = 3;
  localparam int FAR_END_BLOCK_ERROR_SEL_LO = 2;
  localparam int CRC_DET_POS = 1;
  localparam int COMBINED_POS = 0;

  // Far-end error reply selector codes
  localparam logic [1:0] FAR_END_BLOCK_ERROR_SEL_OFF = 2'h0;
  localparam logic [1:0] FAR_END_BLOCK_ERROR_SEL_01 = 2'h1;
  localparam logic [1:0] FAR_END_BLOCK_ERROR_SEL_10 = 2'h2;
  localparam logic [1:0] FAR_END_BLOCK_ERROR_SEL_11 = 2'h3;

  // Fixed Sa6 nibbles sent by the automatic replies
  localparam logic [3:0] SA6_ALL_ONES = 4'hf;
  localparam logic [3:0] SA6_FAR_END_BLOCK_ERROR_LOW = 4'h0;
  localparam logic [3:0] SA6_FAR_END_BLOCK_ERROR_HIGH = 4'h1;
  localparam logic [3:0] SA6_CRC_DET = 4'h2;
  localparam logic [3:0] SA6_COMBINED = 4'h3;

  // Automatic reply in force, shown in the status register
  typedef enum logic [2:0] {
    ENBI_REPLY_NONE,
    ENBI_REPLY_AIS_ONE,
    ENBI_REPLY_AIS_TWO,
    ENBI_REPLY_FAR_END_BLOCK_ERROR_01,
    ENBI_REPLY_FAR_END_BLOCK_ERROR_10,
    ENBI_REPLY_FAR_END_BLOCK_ERROR_11,
    ENBI_REPLY_CRC_DET,
    ENBI_REPLY_COMBINED
  } enbi_reply_t;

  // One outgoing odd-frame overhead word
  typedef struct packed {
    logic [2:0] slot;   // Odd-frame slot 0..7 (frames 2..16)
    logic a_bit;
    logic [4:0] sa;     // Sa4 in bit 4 down to Sa8 in bit 0
    logic e_bit;
  } enbi_word_t;

  // Receive side conditions
  typedef struct packed {
    logic ais;
    logic far_end_block_error;
    logic crc_err;
  } enbi_rx_cond_t;

endpackage

// *** design/enbi_national_insert.sv ***
// E1 transmit national bit insertion with automatic alarm replies
//
// Operation
// (R1) Enabled receive conditions override outgoing A, Sa and E bits with fixed patterns.
// (R2) First AIS reply: A one, Sa5 one, Sa6 ones, E untouched.
// (R3) Second AIS reply: A zero, Sa5 one, Sa6 ones, E untouched.
// (R4) Selector 01 with received E zero: A 0, Sa5 1, Sa6 0000, E 0.
// (R5) Selector 10 with far-end error: A 0, Sa5 0, Sa6 0000, E 0.
// (R6) Selector 11 with far-end error: A 0, Sa5 1, Sa6 0001, E 1.
// (R7) Local CRC-4 error reply: A 0, Sa5 1, Sa6 0010, E 1.
// (R8) Combined far-end and CRC-4 error reply: A 0, Sa5 1, Sa6 0011, E 1.
// (R9) Sa4 pattern register drives Sa4 only when link select and source bits are set.
// (R10) Sa5 pattern register drives Sa5 only when link select and source bits are set.
// (R11) Sa6 pattern register drives Sa6 only when link select and source bits are set.
// (R12) Sa7 pattern register drives Sa7 only when link select and source bits are set.
// (R13) Sa8 pattern register drives Sa8 only when link select and source bits are set.
// (R14) Pattern bit 7 goes out in frame 2, bit 6 in frame 4, downward.
// (R15) Bits 5 to 0 go out in frames 6, 8, 10, 12, 14, 16.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
module enbi_national_insert
  import enbi_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Avalon-MM slave, word addressed by byte address
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Transmit frame timing and default overhead bits
  input wire logic tx_frame_tick,
  input wire logic [3:0] tx_frame_num,
  input wire logic tx_a_in,
  input wire logic [4:0] tx_sa_in,
  input wire logic tx_e_in,
  output logic tx_tick_ready,
  // Receive side conditions
  input wire enbi_rx_cond_t rx_cond,
  // Outgoing overhead words
  output enbi_word_t ovh_data,
  output logic ovh_valid,
  input wire logic ovh_ready
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************

  // Bit of a pattern register for odd-frame slot k, MSB first
  function automatic logic pattern_bit(input logic [7:0] pat, input logic [2:0] k);
    logic [2:0] idx;
    idx = 3'h7 - k;
    return pat[idx];
  endfunction

  // Bit of an Sa6 nibble, repeated per half multiframe, MSB first
  function automatic logic nibble_bit(input logic [3:0] nib, input logic [2:0] k);
    logic [1:0] idx;
    idx = 2'h3 - k[1:0];
    return nib[idx];
  endfunction

  // ****************************************************************
  // Register bus
  // ****************************************************************
  logic [7:0] pattern_r [5];
  logic [4:0] link_select_r;
  logic [4:0] reg_source_r;
  logic [7:0] auto_reply_r;
  logic [7:0] status_word;
  logic [9:0] bus_idx;
  logic bus_req;
  logic bus_go;
  logic [7:0] rd_value;

  // Register index is the byte address over four
  assign bus_idx = avs_address[11:2];
  assign bus_req = avs_read | avs_write;
  assign bus_go = bus_req & ~avs_waitrequest;

  // Wait one cycle per access, then answer for exactly one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_go) begin
      avs_waitrequest <= 1'b1;
    end else if (bus_req) begin
      avs_waitrequest <= 1'b0;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_value = 8'h00;
    unique case (bus_idx)
      IDX_LINK_SELECT: rd_value = {3'h0, link_select_r};
      IDX_REG_SOURCE: rd_value = {3'h0, reg_source_r};
      IDX_AUTO_REPLY: rd_value = auto_reply_r & 8'hcf; // Bits 5:4 reserved
      IDX_STATUS: rd_value = status_word;
      IDX_PATTERN4: rd_value = pattern_r[0];
      IDX_PATTERN5: rd_value = pattern_r[1];
      IDX_PATTERN6: rd_value = pattern_r[2];
      IDX_PATTERN7: rd_value = pattern_r[3];
      IDX_PATTERN8: rd_value = pattern_r[4];
      default: rd_value = 8'h00;
    endcase
  end

  // Read data captured while waitrequest is still high, so it stands on the answer cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, rd_value};
    end
  end

  // Writes take effect only at the edge that completes the access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_select_r <= CTRL_RST[4:0];
      reg_source_r <= CTRL_RST[4:0];
      auto_reply_r <= CTRL_RST;
      for (int i = 0; i < 5; i++) begin
        pattern_r[i] <= PATTERN_RST;
      end
    end else if (bus_go && avs_write && avs_byteenable[0]) begin
      unique case (bus_idx)
        IDX_LINK_SELECT: link_select_r <= avs_writedata[4:0];
        IDX_REG_SOURCE: reg_source_r <= avs_writedata[4:0];
        IDX_AUTO_REPLY: auto_reply_r <= avs_writedata[7:0] & 8'hcf;
        IDX_PATTERN4: pattern_r[0] <= avs_writedata[7:0];
        IDX_PATTERN5: pattern_r[1] <= avs_writedata[7:0];
        IDX_PATTERN6: pattern_r[2] <= avs_writedata[7:0];
        IDX_PATTERN7: pattern_r[3] <= avs_writedata[7:0];
        IDX_PATTERN8: pattern_r[4] <= avs_writedata[7:0];
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Automatic reply selection
  // ****************************************************************
  enbi_reply_t reply_nxt;
  enbi_reply_t reply_r;
  logic [1:0] far_end_block_error_sel;

  assign far_end_block_error_sel = auto_reply_r[FAR_END_BLOCK_ERROR_SEL_HI:FAR_END_BLOCK_ERROR_SEL_LO];

  // AIS outranks error replies; the combined reply outranks its parts
  always_comb begin
    reply_nxt = ENBI_REPLY_NONE;
    if (rx_cond.ais && auto_reply_r[AIS_ONE_POS]) begin
      reply_nxt = ENBI_REPLY_AIS_ONE; // [R1] [R2]
    end else if (rx_cond.ais && auto_reply_r[AIS_TWO_POS]) begin
      reply_nxt = ENBI_REPLY_AIS_TWO; // [R1] [R3]
    end else if (rx_cond.far_end_block_error && rx_cond.crc_err && auto_reply_r[COMBINED_POS]) begin
      reply_nxt = ENBI_REPLY_COMBINED; // [R8]
    end else if (rx_cond.crc_err && auto_reply_r[CRC_DET_POS]) begin
      reply_nxt = ENBI_REPLY_CRC_DET; // [R7]
    end else if (rx_cond.far_end_block_error && far_end_block_error_sel == FAR_END_BLOCK_ERROR_SEL_01) begin
      reply_nxt = ENBI_REPLY_FAR_END_BLOCK_ERROR_01; // [R4]
    end else if (rx_cond.far_end_block_error && far_end_block_error_sel == FAR_END_BLOCK_ERROR_SEL_10) begin
      reply_nxt = ENBI_REPLY_FAR_END_BLOCK_ERROR_10; // [R5]
    end else if (rx_cond.far_end_block_error && far_end_block_error_sel == FAR_END_BLOCK_ERROR_SEL_11) begin
      reply_nxt = ENBI_REPLY_FAR_END_BLOCK_ERROR_11; // [R6]
    end
  end

  // Reply in force, tracked every cycle for status readback
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reply_r <= ENBI_REPLY_NONE;
    end else begin
      reply_r <= reply_nxt;
    end
  end

  // ****************************************************************
  // Overhead word assembly
  // ****************************************************************
  enbi_word_t word_nxt;
  logic [2:0] slot;
  logic [4:0] reg_drive;
  logic odd_frame;
  logic take_tick;

  // Frames 2,4..16 of the multiframe are the odd zero-based numbers
  assign odd_frame = tx_frame_num[0];
  assign slot = tx_frame_num[3:1]; // [R14] [R15]
  assign reg_drive = link_select_r & reg_source_r; // [R9] [R10] [R11] [R12] [R13]

  // Register bits first, then the automatic reply on top of them
  always_comb begin
    word_nxt.slot = slot;
    word_nxt.a_bit = tx_a_in;
    word_nxt.e_bit = tx_e_in;
    word_nxt.sa = tx_sa_in;
    if (reg_drive[SA4_POS]) begin
      word_nxt.sa[SA4_POS] = pattern_bit(pattern_r[0], slot); // [R9] [R14]
    end
    if (reg_drive[SA5_POS]) begin
      word_nxt.sa[SA5_POS] = pattern_bit(pattern_r[1], slot); // [R10] [R14]
    end
    if (reg_drive[SA6_POS]) begin
      word_nxt.sa[SA6_POS] = pattern_bit(pattern_r[2], slot); // [R11] [R15]
    end
    if (reg_drive[SA7_POS]) begin
      word_nxt.sa[SA7_POS] = pattern_bit(pattern_r[3], slot); // [R12] [R15]
    end
    if (reg_drive[SA8_POS]) begin
      word_nxt.sa[SA8_POS] = pattern_bit(pattern_r[4], slot); // [R13] [R15]
    end
    unique case (reply_nxt)
      ENBI_REPLY_NONE: ;
      ENBI_REPLY_AIS_ONE: begin
        word_nxt.a_bit = 1'b1; // [R2]
        word_nxt.sa[SA5_POS] = 1'b1;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_ALL_ONES, slot);
      end
      ENBI_REPLY_AIS_TWO: begin
        word_nxt.a_bit = 1'b0; // [R3]
        word_nxt.sa[SA5_POS] = 1'b1;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_ALL_ONES, slot);
      end
      ENBI_REPLY_FAR_END_BLOCK_ERROR_01: begin
        word_nxt.a_bit = 1'b0; // [R4]
        word_nxt.sa[SA5_POS] = 1'b1;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_FAR_END_BLOCK_ERROR_LOW, slot);
        word_nxt.e_bit = 1'b0;
      end
      ENBI_REPLY_FAR_END_BLOCK_ERROR_10: begin
        word_nxt.a_bit = 1'b0; // [R5]
        word_nxt.sa[SA5_POS] = 1'b0;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_FAR_END_BLOCK_ERROR_LOW, slot);
        word_nxt.e_bit = 1'b0;
      end
      ENBI_REPLY_FAR_END_BLOCK_ERROR_11: begin
        word_nxt.a_bit = 1'b0; // [R6]
        word_nxt.sa[SA5_POS] = 1'b1;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_FAR_END_BLOCK_ERROR_HIGH, slot);
        word_nxt.e_bit = 1'b1;
      end
      ENBI_REPLY_CRC_DET: begin
        word_nxt.a_bit = 1'b0; // [R7]
        word_nxt.sa[SA5_POS] = 1'b1;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_CRC_DET, slot);
        word_nxt.e_bit = 1'b1;
      end
      ENBI_REPLY_COMBINED: begin
        word_nxt.a_bit = 1'b0; // [R8]
        word_nxt.sa[SA5_POS] = 1'b1;
        word_nxt.sa[SA6_POS] = nibble_bit(SA6_COMBINED, slot);
        word_nxt.e_bit = 1'b1;
      end
    endcase
  end

  // ****************************************************************
  // Two-entry output buffer
  // ****************************************************************
  enbi_word_t buf_r [2];
  logic [1:0] count_r;
  logic rd_ptr_r;
  logic wr_ptr_r;
  logic push;
  logic pop;

  // Only odd frames carry national bits; even ticks are accepted and dropped
  assign take_tick = tx_frame_tick & tx_tick_ready;
  assign push = take_tick & odd_frame;
  assign pop = ovh_valid & ovh_ready;

  // Storage and pointers; a full buffer stalls the frame timing source
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      buf_r[0] <= '0;
      buf_r[1] <= '0;
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
    end else begin
      if (push) begin
        buf_r[wr_ptr_r] <= word_nxt;
        wr_ptr_r <= ~wr_ptr_r;
      end
      if (pop) begin
        rd_ptr_r <= ~rd_ptr_r;
      end
    end
  end

  // Occupancy count, with ready and valid registered from it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 2'h0;
    end else if (push && !pop) begin
      count_r <= count_r + 2'h1;
    end else if (pop && !push) begin
      count_r <= count_r - 2'h1;
    end
  end

  // Registered flags follow the count that the next edge will hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovh_valid <= 1'b0;
      tx_tick_ready <= 1'b0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          ovh_valid <= 1'b1;
          tx_tick_ready <= (count_r == 2'h0);
        end
        2'b01: begin
          ovh_valid <= (count_r == 2'h2);
          tx_tick_ready <= 1'b1;
        end
        default: begin
          ovh_valid <= (count_r != 2'h0);
          tx_tick_ready <= (count_r != 2'h2);
        end
      endcase
    end
  end

  // Output word from a flop; follows the head of the buffer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovh_data <= '0;
    end else if (pop) begin
      ovh_data <= (count_r == 2'h2) ? buf_r[~rd_ptr_r] : word_nxt;
    end else if (count_r == 2'h0 && push) begin
      ovh_data <= word_nxt;
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  logic [3:0] last_frame_r;

  // Last accepted frame number, for software to see the timing running
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      last_frame_r <= 4'h0;
    end else if (take_tick) begin
      last_frame_r <= tx_frame_num;
    end
  end

  // Reply code in bits 6:4, frame in 3:0, buffer full in bit 7
  assign status_word = {count_r == 2'h2, reply_r, last_frame_r};

endmodule

// *** tb/enbi_national_insert_checker.sv ***
// Port assertions for the national bit insertion block
`timescale 1ns/100ps
module enbi_national_insert_checker
  import enbi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Frame side
  input wire logic tx_frame_tick,
  input wire logic [3:0] tx_frame_num,
  input wire logic tx_tick_ready,
  // Overhead stream
  input wire enbi_word_t ovh_data,
  input wire logic ovh_valid,
  input wire logic ovh_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic take_w;
  logic [2:0] slot_r;
  // A tick counts only when the block is ready for it
  assign take_w = tx_frame_tick && tx_tick_ready;
  // Slot of the tick just taken, compared one cycle later
  always_ff @(posedge ref_clk) begin
    slot_r <= tx_frame_num[3:1];
  end
  // ****************************************************************
  // Bus and stream relations
  // ****************************************************************
  wait_one_a:
    assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
  wait_pulse_a:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("bus answer longer than one cycle");
  idle_wait_a:
    assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("bus answer without request");
  read_upper_a:
    assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  word_hold_a:
    assert property (ovh_valid && !ovh_ready |=> ovh_valid && $stable(ovh_data))
    else $error("word changed before accept");
  push_slot_a:
    assert property (take_w && tx_frame_num[0] && !ovh_valid |=> ovh_valid && ovh_data.slot == slot_r)
    else $error("odd frame word missing or wrong slot");
  even_none_a:
    assert property (take_w && !tx_frame_num[0] && !ovh_valid |=> !ovh_valid)
    else $error("even frame produced a word");
  full_stop_a:
    assert property (take_w && tx_frame_num[0] && ovh_valid && !ovh_ready |=> !tx_tick_ready)
    else $error("tick ready high with full buffer");
  free_again_a:
    assert property (!tx_tick_ready && ovh_valid && ovh_ready |=> tx_tick_ready)
    else $error("tick ready stuck after pop");
  // Main scenarios reached
  full_c: cover property (!tx_tick_ready && ovh_valid);
  write_c: cover property (avs_write && !avs_waitrequest);
  reply_c: cover property (ovh_valid && ovh_ready && ovh_data.e_bit);
endmodule

// *** tb/enbi_line_sink.sv ***
// Far-end overhead consumer that accepts promptly, slowly or not at all
`timescale 1ns/100ps
module enbi_line_sink
  import enbi_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Overhead stream from the block
  input wire logic ovh_valid,
  output logic ovh_ready,
  // Pace: 0 prompt, 1 every other cycle, 2 stalled
  input wire logic [1:0] pace
);
  logic phase_r;
  // Ready moves only after an edge, so a word is never half taken
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovh_ready <= 1'b0;
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r;
      ovh_ready <= (pace == 2'h0) || (pace == 2'h1 && phase_r);
    end
  end
endmodule

// *** tb/enbi_national_insert_tb_top.sv ***
// Self-checking bench for the national bit insertion block
`timescale 1ns/100ps
module enbi_national_insert_tb_top
  import enbi_pkg::*;
();
  // Reply case: control, conditions, frame, default bits, expected word
  typedef struct packed {
    logic [7:0] ctl;
    logic [2:0] cnd;
    logic [3:0] fn;
    logic [6:0] dfl;
    enbi_word_t exp;
  } enbi_row_t;
  logic ref_clk, rst_n, avs_read, avs_write, avs_waitrequest, b;
  logic [11:0] avs_address;
  logic [3:0] avs_byteenable, tx_frame_num;
  logic [31:0] avs_writedata, avs_readdata;
  logic tx_frame_tick, tx_a_in, tx_e_in, tx_tick_ready, ovh_valid, ovh_ready;
  logic [4:0] tx_sa_in, es;
  logic [1:0] pace;
  logic [7:0] rd, pat, oh;
  enbi_rx_cond_t rx_cond;
  enbi_word_t ovh_data, w, exp_w;
  int n_mismatch, comparisons;
  localparam enbi_row_t ROWS [11] = '{
    '{8'h00, 3'h7, 4'h1, 7'h6b, 10'h06b},
    '{8'h80, 3'h4, 4'h1, 7'h00, 10'h058},
    '{8'h80, 3'h4, 4'h3, 7'h01, 10'h0d9},
    '{8'h40, 3'h4, 4'h5, 7'h67, 10'h13f},
    '{8'h04, 3'h2, 4'h7, 7'h5f, 10'h196},
    '{8'h04, 3'h1, 4'h3, 7'h6b, 10'h0eb},
    '{8'h08, 3'h2, 4'h9, 7'h5f, 10'h206},
    '{8'h0c, 3'h2, 4'hf, 7'h40, 10'h399},
    '{8'h02, 3'h1, 4'hd, 7'h40, 10'h319},
    '{8'h01, 3'h3, 4'hb, 7'h48, 10'h291},
    '{8'h01, 3'h2, 4'h1, 7'h6b, 10'h06b}
  };
  enbi_national_insert #(.ADDR_W(12)) DUT (
    .ref_clk(ref_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_frame_tick(tx_frame_tick), .tx_frame_num(tx_frame_num), .tx_a_in(tx_a_in),
    .tx_sa_in(tx_sa_in), .tx_e_in(tx_e_in), .tx_tick_ready(tx_tick_ready),
    .rx_cond(rx_cond), .ovh_data(ovh_data), .ovh_valid(ovh_valid), .ovh_ready(ovh_ready));
  enbi_line_sink u_sink (.ref_clk(ref_clk), .rst_n(rst_n), .ovh_valid(ovh_valid),
    .ovh_ready(ovh_ready), .pace(pace));
  // 100 MHz clock
  always #5 ref_clk = ~ref_clk;
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // A wait that runs out counts as a mismatch and ends the run
  task automatic give_up();
    n_mismatch++;
    conclude();
  endtask
  // One bus access, held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
    int n;
    @(posedge ref_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest && n < 20);
    if (avs_waitrequest) give_up();
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // Tick is held until the block is ready to take it
  task automatic tick(input logic [3:0] fn);
    int n;
    @(posedge ref_clk);
    tx_frame_tick <= 1'b1;
    tx_frame_num <= fn;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!tx_tick_ready && n < 50);
    if (!tx_tick_ready) give_up();
    @(posedge ref_clk);
    tx_frame_tick <= 1'b0;
  endtask
  // Next word handed to the far end
  task automatic take();
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (!(ovh_valid && ovh_ready) && n < 50);
    if (!(ovh_valid && ovh_ready)) give_up();
    w = ovh_data;
    @(posedge ref_clk);
  endtask
  // Reset for two cycles, outputs idle meanwhile
  task automatic do_reset();
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk("reset idle", {avs_waitrequest, ovh_valid, tx_tick_ready}, 3'b100);
    rst_n <= 1'b1;
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    {avs_read, avs_write, tx_frame_tick, tx_a_in, tx_e_in} = '0;
    {avs_address, avs_writedata, tx_frame_num, tx_sa_in} = '0;
    avs_byteenable = 4'hf;
    rx_cond = '0;
    pace = 2'h1;
    n_mismatch = 0;
    comparisons = 0;
    do_reset();
    for (int i = 0; i < 11; i++) begin
      bus(1'b1, IDX_AUTO_REPLY, ROWS[i].ctl);
      rx_cond <= ROWS[i].cnd;
      {tx_a_in, tx_sa_in, tx_e_in} <= ROWS[i].dfl;
      tick(ROWS[i].fn);
      take();
      chk("reply word", w, ROWS[i].exp);
    end
    // Each Sa from its register only with both select bits; defaults elsewhere
    bus(1'b1, IDX_AUTO_REPLY, 8'h00);
    {rx_cond, tx_a_in, tx_e_in, pace} <= '0;
    for (int p = 0; p < 5; p++) begin
      pat = 8'h35 + 8'(p * 7);
      oh = 8'h10 >> p;
      bus(1'b1, IDX_PATTERN4 + 10'(p), pat);
      bus(1'b1, IDX_LINK_SELECT, p[0] ? 8'h1f : oh);
      bus(1'b1, IDX_REG_SOURCE, p[0] ? oh : 8'h1f);
      for (int k = 0; k < 8; k++) begin
        b = pat[7-k];
        tx_sa_in <= {5{~b}};
        tick({k[2:0], 1'b1});
        take();
        es = {5{~b}};
        es[4-p] = b;
        exp_w = {3'(k), 1'b0, es, 1'b0};
        chk("register sa bits", w, exp_w);
      end
    end
    // Even frame gives nothing; then fill the buffer with the far end stalled
    tick(4'h2);
    repeat (3) @(negedge ref_clk);
    chk("even frame valid", ovh_valid, 1'b0);
    @(posedge ref_clk);
    pace <= 2'h2;
    tick(4'h1);
    tick(4'h3);
    @(negedge ref_clk);
    chk("tick ready when full", tx_tick_ready, 1'b0);
    // Status shows the full buffer, no reply in force and the last frame taken
    bus(1'b0, IDX_STATUS, 8'h00);
    chk("status full", rd, 8'h83);
    @(posedge ref_clk);
    pace <= 2'h0;
    take();
    chk("first slot", w.slot, 3'h0);
    take();
    chk("second slot", w.slot, 3'h1);
    // Second reset mid-run, then reset values, reserved bits, odd accesses
    do_reset();
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, (i < 3) ? 10'h10a + 10'(i == 1 ? 38 : 0) + 10'(i == 2 ? 39 : 0)
                        : IDX_PATTERN4 + 10'(i - 3), 8'h00);
      chk("reset value", rd, (i < 3) ? CTRL_RST : PATTERN_RST);
    end
    bus(1'b1, IDX_AUTO_REPLY, 8'hff);
    bus(1'b0, IDX_AUTO_REPLY, 8'h00);
    chk("reply control", rd, 8'hcf);
    bus(1'b0, 10'h200, 8'h00);
    chk("unmapped read", rd, 8'h00);
    @(posedge ref_clk);
    avs_byteenable <= 4'h0;
    bus(1'b1, IDX_PATTERN4, 8'h00);
    avs_byteenable <= 4'hf;
    bus(1'b0, IDX_PATTERN4, 8'h00);
    chk("masked write", rd, PATTERN_RST);
    conclude();
  end
endmodule
bind enbi_national_insert enbi_national_insert_checker u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_frame_tick(tx_frame_tick), .tx_frame_num(tx_frame_num),
  .tx_tick_ready(tx_tick_ready), .ovh_data(ovh_data), .ovh_valid(ovh_valid),
  .ovh_ready(ovh_ready));
